/* core/tmc_boot.sv */
// Boot integrity check and status indicator sequencer
module tmc_boot
  import tmc_pkg::*;
#(
  parameter int LED_STEP = LED_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic start,
  input wire logic crc_done,
  input wire logic crc_ok,
  input wire logic boot_err,
  output tmc_led_t led,
  output logic running,
  output logic boot_alarm
);

  // ----------------------------------------------------------------
  // Boot state machine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    B_CHECK, B_RED, B_YELLOW, B_GREEN, B_RUN, B_HALT, B_FAIL
  } tmc_boot_t;

  tmc_boot_t state;   // Current state
  logic [31:0] timer; // LED step timer
  logic blink;        // Red blink phase

  wire step_done = (timer == 32'(LED_STEP - 1));  // Step elapsed

  // Sequence and hold states
  always_ff @(posedge clk_sys) begin
    if (sys_rst || start) begin
      state <= B_CHECK;
      timer <= '0;
      blink <= 1'b0;
      boot_alarm <= 1'b0;
    end else if (clk_en) begin
      timer <= step_done ? '0 : timer + 32'h1;
      boot_alarm <= 1'b0;
      case (state)
        B_CHECK: begin
          if (boot_err) begin
            state <= B_FAIL;
            boot_alarm <= 1'b1;
          end else if (crc_done) begin
            state <= crc_ok ? B_RED : B_HALT;
            timer <= '0;
          end
        end
        B_RED: if (step_done) state <= B_YELLOW;
        B_YELLOW: if (step_done) state <= B_GREEN;
        B_GREEN: if (step_done) state <= B_RUN;
        B_HALT: if (step_done) blink <= ~blink;
        default: state <= state;
      endcase
    end
  end

  // LED colour per state
  always_comb begin
    case (state)
      B_RED: led = LED_RED;
      B_YELLOW: led = LED_YELLOW;
      B_GREEN, B_RUN: led = LED_GREEN;
      B_HALT: led = blink ? LED_OFF : LED_RED;
      B_FAIL: led = LED_RED;
      default: led = LED_OFF;
    endcase
  end

  assign running = (state == B_RUN);

endmodule // tmc_boot

/* core/tmc_ctrl.sv */
// Transmitter mode controller: gain modes, enables and quick-swap
//
// Behaviour
// - Check firmware CRC before running
// - CRC failure halts, blinks indicator red
// - Good boot shows red, yellow, green
// - Other boot error: steady red, alarm
// - Preset loop tracks calibrated reference power
// - Offset mode accepts quarter-decibel steps
// - New offset held and stored
// - Offset reload: preset level, then offset
// - Secondary toggle only in automatic modes
// - Video lowers level by 2-5 dB
// - Reset defaults: preset, video, 4 dB
// - Manual: tenth-decibel steps, no correction
// - Entering manual recalls stored attenuator
// - Manual reload stores current attenuator
// - Optical output control, default on
// - RF drive control, default on
// - Optical off forces and locks RF
// - Optical on restores earlier RF state
// - Quick-swap message reinitializes settings
// - Level source follows primary mode
// - Reject message for other module type
// - Optical off: maximum attenuation, restore
//
// Local design decisions: the address map and the address-and-strobe port.
module tmc_ctrl
  import tmc_pkg::*;
#(
  parameter logic [7:0] MODULE_TYPE = 8'h5A,  // Arbitrary type code
  parameter int LOOP_STEP = LOOP_CYC,
  parameter int LED_STEP = LED_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input tmc_bus_t bus,
  output logic [15:0] rdata,
  input wire logic crc_done,
  input wire logic crc_ok,
  input wire logic boot_err,
  input wire logic [7:0] meas_power,
  input wire logic [7:0] cal_ref,
  input wire logic opt_cmd_local,
  input wire logic opt_cmd_mgmt,
  input wire logic opt_cmd_display,
  input wire logic opt_cmd_val,
  input wire logic cfg_valid,
  input tmc_cfg_t cfg,
  output logic cfg_reject,
  output tmc_led_t led,
  output logic boot_alarm,
  output logic [ATT_W-1:0] atten,
  output logic laser_on,
  output logic rf_drive_on,
  output logic [7:0] alias_id
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  tmc_pri_t pri;              // Primary mode
  logic video;                // Secondary mode, 1 video
  logic [1:0] vofs;           // Video offset code: 2..5 dB
  logic [7:0] mod_ofs;        // Modulation offset, 0.25 dB steps
  logic [7:0] nvm_ofs;        // Stored offset
  logic [7:0] nvm_man;        // Stored manual attenuator
  logic [ATT_W-1:0] att_set;  // Attenuator working value
  logic opt_en;               // Optical output enable
  logic rf_req;               // RF state requested or remembered
  logic [31:0] loop_cnt;      // Loop interval counter
  logic running;              // Boot finished
  logic restart;              // Reinitialize after quick-swap

  // ----------------------------------------------------------------
  // Boot sequencer
  // ----------------------------------------------------------------
  tmc_boot #(
    .LED_STEP(LED_STEP)
  ) u_boot (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .start(restart),
    .crc_done(crc_done),
    .crc_ok(crc_ok),
    .boot_err(boot_err),
    .led(led),
    .running(running),
    .boot_alarm(boot_alarm)
  );

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  wire wr_ctrl = bus.wr && (bus.addr == ADDR_CTRL);
  wire wr_mode = bus.wr && (bus.addr == ADDR_MODE);
  wire wr_ofs = bus.wr && (bus.addr == ADDR_OFFSET);
  wire wr_att = bus.wr && (bus.addr == ADDR_ATTEN);
  wire [2:0] cmd = bus.wdata[2:0];
  wire is_auto = (pri != PRI_MANUAL);
  wire opt_cmd = opt_cmd_local | opt_cmd_mgmt | opt_cmd_display;
  wire opt_wr = wr_ctrl | opt_cmd;
  wire opt_val = wr_ctrl ? bus.wdata[CTRL_OPT_BIT] : opt_cmd_val;
  wire cfg_match = cfg_valid && (cfg.module_type == MODULE_TYPE);
  wire loop_tick = (loop_cnt == 32'(LOOP_STEP - 1));

  // Video offset in 0.25 dB units: (code + 2) * 4
  wire [7:0] vofs_q = {4'h0, 2'(vofs) + 2'h0, 2'h0} + 8'h08;

  // Target power: reference plus offset, minus video drop
  wire [7:0] ofs_use = (pri == PRI_OFFSET) ? mod_ofs : 8'h00;
  wire [7:0] vid_drop = video ? vofs_q : 8'h00;
  wire [7:0] target = cal_ref + ofs_use - vid_drop;
  wire too_low = (meas_power + DEAD_BAND) < target;
  wire too_high = meas_power > (target + DEAD_BAND);

  // Next attenuator value for the automatic loop
  logic [ATT_W-1:0] next_att;
  always_comb begin
    next_att = att_set;
    if (too_low && att_set != '0) begin
      next_att = att_set - 1'b1;
    end else if (too_high && att_set != ATT_MAX) begin
      next_att = att_set + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Loop interval timer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      loop_cnt <= '0;
    end else if (clk_en) begin
      loop_cnt <= loop_tick ? '0 : loop_cnt + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Mode, offset and attenuator control
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pri <= PRI_PRESET;
      video <= 1'b1;
      vofs <= VOFS_RESET;
      mod_ofs <= OFS_RESET;
      nvm_ofs <= OFS_RESET;
      nvm_man <= ATT_MAX;
      att_set <= ATT_MAX;
      alias_id <= 8'h00;
      restart <= 1'b0;
      cfg_reject <= 1'b0;
    end else if (clk_en) begin
      restart <= 1'b0;
      cfg_reject <= 1'b0;
      if (cfg_valid) begin
        if (cfg_match) begin
          alias_id <= cfg.alias_id;
          pri <= tmc_pri_t'(cfg.primary);
          video <= cfg.video;
          vofs <= cfg.vofs;
          mod_ofs <= cfg.mod_ofs;
          nvm_ofs <= cfg.mod_ofs;
          nvm_man <= cfg.atten;
          att_set <= cfg.atten;
          restart <= 1'b1;
        end else begin
          cfg_reject <= 1'b1;
        end
      end else if (running) begin
        if (wr_mode) begin
          if (is_auto) begin
            video <= bus.wdata[MODE_SEC_BIT];
          end
          vofs <= bus.wdata[MODE_VOFS_LSB +: 2];
          if (cmd == CMD_PRESET) begin
            pri <= PRI_PRESET;
          end else if (cmd == CMD_OFFSET) begin
            pri <= PRI_OFFSET;
            mod_ofs <= nvm_ofs;
          end else if (cmd == CMD_MANUAL) begin
            pri <= PRI_MANUAL;
            att_set <= nvm_man;
          end else if (cmd == CMD_OFS_RELOAD) begin
            mod_ofs <= OFS_RESET;
            nvm_ofs <= OFS_RESET;
            pri <= PRI_OFFSET;
          end else if (cmd == CMD_MAN_RELOAD) begin
            nvm_man <= att_set;
            pri <= PRI_MANUAL;
          end
        end else if (wr_ofs && pri == PRI_OFFSET) begin
          mod_ofs <= bus.wdata[7:0];
          nvm_ofs <= bus.wdata[7:0];
        end else if (wr_att && pri == PRI_MANUAL) begin
          att_set <= bus.wdata[ATT_W-1:0];
          nvm_man <= bus.wdata[ATT_W-1:0];
        end else if (is_auto && loop_tick && opt_en) begin
          att_set <= next_att;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Optical and RF enables
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      opt_en <= 1'b1;
      rf_req <= 1'b1;
    end else if (clk_en) begin
      if (cfg_match) begin
        opt_en <= cfg.opt_en;
        rf_req <= cfg.rf_en;
      end else begin
        if (opt_wr) begin
          opt_en <= opt_val;
        end
        if (wr_ctrl && opt_en) begin
          rf_req <= bus.wdata[CTRL_RF_BIT];
        end
      end
    end
  end

  // Outputs gated by the optical interlock
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      laser_on <= 1'b0;
      rf_drive_on <= 1'b0;
      atten <= ATT_MAX;
    end else if (clk_en) begin
      laser_on <= opt_en && running;
      rf_drive_on <= opt_en && rf_req && running;
      // Laser dark for any reason: park the attenuator at maximum
      atten <= (opt_en && running) ? att_set : ATT_MAX;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [15:0] next_rdata;
  always_comb begin
    next_rdata = 16'h0000;
    if (bus.addr == ADDR_CTRL) begin
      next_rdata = {14'h0000, rf_req, opt_en};
    end else if (bus.addr == ADDR_MODE) begin
      next_rdata = {9'h000, vofs, video, 2'h0, pri};
    end else if (bus.addr == ADDR_OFFSET) begin
      next_rdata = {8'h00, mod_ofs};
    end else if (bus.addr == ADDR_ATTEN) begin
      next_rdata = {8'h00, att_set};
    end else if (bus.addr == ADDR_STATUS) begin
      next_rdata = {12'h000, led, rf_drive_on, running};
    end else if (bus.addr == ADDR_POWER) begin
      next_rdata = {meas_power, target};
    end else if (bus.addr == ADDR_NVM_OFS) begin
      next_rdata = {8'h00, nvm_ofs};
    end else if (bus.addr == ADDR_NVM_MAN) begin
      next_rdata = {8'h00, nvm_man};
    end
  end

  // Read data registered one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata <= 16'h0000;
    end else if (clk_en) begin
      rdata <= bus.rd ? next_rdata : 16'h0000;
    end
  end

endmodule // tmc_ctrl

/* pkg/tmc_pkg.sv */
// Package of constants and types for the transmitter mode controller
package tmc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;     // Optical and RF enables
  localparam logic [3:0] ADDR_MODE = 4'h1;     // Mode and sub-mode command
  localparam logic [3:0] ADDR_OFFSET = 4'h2;   // Modulation offset steps
  localparam logic [3:0] ADDR_ATTEN = 4'h3;    // Manual attenuator
  localparam logic [3:0] ADDR_STATUS = 4'h4;   // Boot, indicator and RF drive status
  localparam logic [3:0] ADDR_POWER = 4'h5;    // Measured and target
  localparam logic [3:0] ADDR_NVM_OFS = 4'h6;  // Stored offset
  localparam logic [3:0] ADDR_NVM_MAN = 4'h7;  // Stored manual attenuator

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int CTRL_OPT_BIT = 0;   // Optical output enable
  localparam int CTRL_RF_BIT = 1;    // RF drive enable
  localparam int MODE_SEC_BIT = 4;   // Secondary mode: 1 video
  localparam int MODE_VOFS_LSB = 5;  // Video offset code, 2 bits

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int ATT_W = 8;                          // Attenuator code
  localparam logic [7:0] ATT_MAX = 8'hFF;            // Full attenuation
  localparam logic [7:0] OFS_RESET = 8'h00;          // Offset in 0.25 dB
  localparam logic [1:0] VOFS_RESET = 2'h2;          // 4 dB
  localparam logic [7:0] DEAD_BAND = 8'h02;          // Loop dead band

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 125;                      // System clock
  localparam int LOOP_US = 100;                      // Loop interval
  localparam int LOOP_CYC = LOOP_US * CLK_MHZ;       // Cycles per step
  localparam int LED_MS = 250;                       // LED step time
  localparam int LED_CYC = LED_MS * 1000 * CLK_MHZ;  // Cycles per step

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_PRESET = 3'h0,
    CMD_OFFSET = 3'h1,
    CMD_MANUAL = 3'h2,
    CMD_OFS_RELOAD = 3'h3,
    CMD_MAN_RELOAD = 3'h4
  } tmc_cmd_t;

  typedef enum logic [1:0] {
    PRI_PRESET = 2'h0,
    PRI_OFFSET = 2'h1,
    PRI_MANUAL = 2'h2
  } tmc_pri_t;

  typedef enum logic [1:0] {
    LED_OFF = 2'h0,
    LED_RED = 2'h1,
    LED_YELLOW = 2'h2,
    LED_GREEN = 2'h3
  } tmc_led_t;

  // Quick-swap configuration message
  typedef struct packed {
    logic [7:0] module_type;  // Target module type
    logic [7:0] alias_id;     // Module alias
    logic rf_en;              // RF drive enable
    logic opt_en;             // Optical output enable
    logic [1:0] primary;      // Primary mode
    logic video;              // Secondary mode
    logic [1:0] vofs;         // Video offset code
    logic [7:0] mod_ofs;      // Modulation offset
    logic [7:0] atten;        // Attenuator setting
  } tmc_cfg_t;

  // Register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } tmc_bus_t;

endpackage : tmc_pkg

/* tb/tmc_ctrl_assertions.sv */
// Port checker of the transmitter mode controller
module tmc_ctrl_assertions
  import tmc_pkg::*;
#(
  parameter logic [7:0] MODULE_TYPE = 8'h5A  // Arbitrary type code
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire tmc_bus_t bus,
  input wire logic [15:0] rdata,
  input wire logic cfg_valid,
  input wire tmc_cfg_t cfg,
  input wire logic cfg_reject,
  input wire tmc_led_t led,
  input wire logic boot_alarm,
  input wire logic [ATT_W-1:0] atten,
  input wire logic laser_on,
  input wire logic rf_drive_on,
  input wire logic [7:0] alias_id
);
  // ------------------------------------------------------------
  // Helper state
  // ------------------------------------------------------------
  logic rf_saved;  // RF state last seen while the laser was on
  // Track RF drive while the laser is on, default on after reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rf_saved <= 1'h1;
    end else if (laser_on) begin
      rf_saved <= rf_drive_on;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------------------
  // Sequences and assertions
  // ------------------------------------------------------------
  sequence wrong_msg_s;  // Message for another module type
    cfg_valid && clk_en && cfg.module_type != MODULE_TYPE;
  endsequence
  sequence to_yellow_s;
    $changed(led) && led == LED_YELLOW;
  endsequence
  sequence to_green_s;
    $changed(led) && led == LED_GREEN;
  endsequence
  rf_lock_a: assert property (!laser_on |-> !rf_drive_on)
    else $error("RF drive on while laser off");
  att_max_a: assert property ((!laser_on) [*2] |-> atten == ATT_MAX)
    else $error("Attenuator not at maximum with laser off");
  rf_back_a: assert property ($rose(laser_on) |-> rf_drive_on == rf_saved)
    else $error("RF drive not restored with laser");
  reject_a: assert property (wrong_msg_s |=> cfg_reject)
    else $error("Foreign message not rejected");
  reject_cause_a: assert property (cfg_reject |->
    $past(cfg_valid) && $past(cfg.module_type) != MODULE_TYPE)
    else $error("Reject without foreign message");
  alias_keep_a: assert property (wrong_msg_s |=>
    $stable(alias_id) ##1 $stable(alias_id))
    else $error("Alias changed by foreign message");
  read_idle_a: assert property (!(bus.rd && clk_en) |=> rdata == 16'h0000)
    else $error("Read data outside read answer");
  yellow_a: assert property (to_yellow_s |-> $past(led) == LED_RED)
    else $error("Yellow not after red");
  green_a: assert property (to_green_s |-> $past(led) == LED_YELLOW)
    else $error("Green not after yellow");
  alarm_red_a: assert property (boot_alarm |-> ##[0:2] led == LED_RED)
    else $error("Boot alarm without red indicator");
endmodule  // tmc_ctrl_assertions

bind tmc_ctrl tmc_ctrl_assertions #(.MODULE_TYPE(MODULE_TYPE)) i_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .bus(bus),
  .rdata(rdata), .cfg_valid(cfg_valid), .cfg(cfg),
  .cfg_reject(cfg_reject), .led(led), .boot_alarm(boot_alarm),
  .atten(atten), .laser_on(laser_on), .rf_drive_on(rf_drive_on),
  .alias_id(alias_id));

/* tb/tmc_ctrl_test.sv */
// Self-checking bench of the transmitter mode controller
module tmc_ctrl_test
  import tmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(nm, exp, got) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("Error %s expected %h seen %h", nm, exp, got); \
    end \
  end
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int LOOP_N = 4;  // Short loop interval
  localparam int LED_N = 3;  // Short indicator step
  localparam logic [7:0] TYPE_ID = 8'h5A;  // Arbitrary type code
  typedef struct packed {
    logic bus;  // 1 bus write, 0 optical command
    logic [1:0] arg;  // Control bits or command source
    logic val;  // Optical command value
    logic laser;
    logic rf;
  } tmc_row_t;
  tmc_row_t rows [7] = '{'{1'h1, 2'h1, 1'h0, 1'h1, 1'h0},
    '{1'h0, 2'h2, 1'h0, 1'h0, 1'h0}, '{1'h1, 2'h2, 1'h0, 1'h0, 1'h0},
    '{1'h0, 2'h0, 1'h1, 1'h1, 1'h0}, '{1'h1, 2'h3, 1'h0, 1'h1, 1'h1},
    '{1'h0, 2'h1, 1'h0, 1'h0, 1'h0}, '{1'h0, 2'h2, 1'h1, 1'h1, 1'h1}};
  logic clk_sys = 1'h0;
  logic sys_rst = 1'h1;
  logic clk_en = 1'h1;  // Clock enable, low freezes the block
  tmc_bus_t bus = '0;
  logic crc_done = 1'h0, crc_ok = 1'h0, boot_err = 1'h0;
  logic [7:0] meas_power = 8'h80, cal_ref = 8'h80;
  logic [3:0] opt_cmd = 4'h0;  // Value, display, mgmt, local
  logic [15:0] rdata, rd_val;
  logic cfg_valid, cfg_reject, boot_alarm, laser_on, rf_drive_on, alarm;
  tmc_cfg_t cfg, msg;
  tmc_led_t led;
  logic [7:0] atten, alias_id, prev;
  logic [5:0] seq;  // Indicator colours seen, newest lowest
  int fail_count = 0, tests_run = 0, offs, last, steps;
  always #4 clk_sys = ~clk_sys;
  tmc_ctrl #(.MODULE_TYPE(TYPE_ID), .LOOP_STEP(LOOP_N),
    .LED_STEP(LED_N)) i_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .bus(bus),
    .rdata(rdata), .crc_done(crc_done), .crc_ok(crc_ok),
    .boot_err(boot_err), .meas_power(meas_power), .cal_ref(cal_ref),
    .opt_cmd_local(opt_cmd[0]), .opt_cmd_mgmt(opt_cmd[1]),
    .opt_cmd_display(opt_cmd[2]), .opt_cmd_val(opt_cmd[3]),
    .cfg_valid(cfg_valid), .cfg(cfg), .cfg_reject(cfg_reject),
    .led(led), .boot_alarm(boot_alarm), .atten(atten),
    .laser_on(laser_on), .rf_drive_on(rf_drive_on), .alias_id(alias_id));
  tmc_shelf_model i_shelf (.clk_sys(clk_sys), .cfg(cfg),
    .cfg_valid(cfg_valid));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  // Register write, waits until the outputs follow
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge clk_sys);
    bus.wr <= 1'h0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  // Register read, data taken in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'h0, rd: 1'h1};
    @(posedge clk_sys);
    bus.rd <= 1'h0;
    #1 rd_val = rdata;
  endtask
  task automatic do_reset;
    sys_rst <= 1'h1;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'h0;
  endtask
  // Boot result pulse, then record the indicator colours
  task automatic boot(input logic ok, input logic err, input int n);
    seq = '0;
    offs = 0;
    alarm = 1'h0;
    @(posedge clk_sys);
    crc_done <= ~err;
    crc_ok <= ok;
    boot_err <= err;
    @(posedge clk_sys);
    {crc_done, boot_err} <= 2'h0;
    #1 alarm = boot_alarm;  // Alarm pulse stands in this cycle only
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      alarm = alarm | boot_alarm;
      if (led !== seq[1:0] && led !== LED_OFF) seq = {seq[3:0], led};
      if (led === LED_OFF && seq !== '0) offs++;
    end
  endtask
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (3000) @(posedge clk_sys);
    fail_count++;
    stop_test;
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys);
    #1 `CHK("reset outputs", {LED_OFF, ATT_MAX, 18'h0},
      {led, atten, laser_on, rf_drive_on, rdata})
    @(posedge clk_sys);
    sys_rst <= 1'h0;
    boot(1'h0, 1'h0, 40);
    `CHK("crc fail blink", 7'h03, {seq, offs > 0})
    do_reset;
    boot(1'h0, 1'h1, 40);
    `CHK("boot error red", {6'h01, 32'h0}, {seq, offs})
    `CHK("boot alarm", 1'h1, alarm)
    do_reset;
    boot(1'h1, 1'h0, 40);
    `CHK("boot sequence", 6'h1B, seq)
    `CHK("default enables", 2'h3, {laser_on, rf_drive_on})
    rd(ADDR_NVM_OFS);
    `CHK("default offset", {8'h00, OFS_RESET}, rd_val)
    rd(ADDR_MODE);
    `CHK("default mode", {9'h0, VOFS_RESET, 5'h10}, rd_val)
    rd(4'hF);
    `CHK("unmapped read", 16'h0000, rd_val)
    // Preset loop chasing a far reference
    meas_power <= 8'h00;
    last = -100;
    steps = 0;
    prev = atten;
    for (int i = 0; i < 80; i++) begin
      @(posedge clk_sys);
      #1;
      if (atten !== prev) begin
        steps++;
        `CHK("step size", 1'h1, atten == prev + 8'h01 || atten == prev - 8'h01)
        `CHK("step spacing", 1'h1, i - last >= LOOP_N)
        last = i;
        prev = atten;
      end
    end
    `CHK("loop tracks", 1'h1, steps > 3)
    `CHK("loop lowers", 1'h1, prev < ATT_MAX)
    // Clock enable low freezes the loop
    clk_en <= 1'h0;
    prev = atten;
    repeat (10) @(posedge clk_sys);
    #1 `CHK("freeze", prev, atten)
    clk_en <= 1'h1;
    wr(ADDR_MODE, 16'h0004);
    prev = atten;
    rd(ADDR_NVM_MAN);
    `CHK("manual reload", {8'h00, prev}, rd_val)
    wr(ADDR_ATTEN, 16'h0040);
    meas_power <= 8'hF0;
    repeat (20) @(posedge clk_sys);
    #1 `CHK("manual holds", 8'h40, atten)
    rd(ADDR_NVM_MAN);
    `CHK("manual stored", 16'h0040, rd_val)
    wr(ADDR_MODE, 16'h0000);
    repeat (20) @(posedge clk_sys);
    wr(ADDR_OFFSET, 16'h0007);
    wr(ADDR_MODE, 16'h0002);
    `CHK("manual recall", 8'h40, atten)
    rd(ADDR_NVM_OFS);
    `CHK("offset refused", 16'h0000, rd_val)
    wr(ADDR_MODE, 16'h0001);
    wr(ADDR_OFFSET, 16'h0007);
    rd(ADDR_NVM_OFS);
    `CHK("offset stored", 16'h0007, rd_val)
    wr(ADDR_MODE, 16'h0003);
    rd(ADDR_NVM_OFS);
    `CHK("offset reload", 16'h0000, rd_val)
    wr(ADDR_MODE, 16'h0002);
    wr(ADDR_MODE, 16'h0072);
    rd(ADDR_MODE);
    `CHK("video ignored", 16'h0062, rd_val)
    // Optical and RF enables from every source
    foreach (rows[i]) begin
      if (rows[i].bus) begin
        wr(ADDR_CTRL, {14'h0000, rows[i].arg});
      end else begin
        @(posedge clk_sys);
        opt_cmd <= {rows[i].val, 3'h0} | (4'h1 << rows[i].arg);
        @(posedge clk_sys);
        opt_cmd <= 4'h0;
        repeat (3) @(posedge clk_sys);
        #1;
      end
      `CHK("enables", {rows[i].laser, rows[i].rf}, {laser_on, rf_drive_on})
      `CHK("level", rows[i].laser ? 8'h40 : ATT_MAX, atten)
    end
    // Quick-swap, foreign type first
    msg = '{module_type: 8'hA5, alias_id: 8'h33, rf_en: 1'h1,
      opt_en: 1'h1, primary: PRI_MANUAL, video: 1'h1, vofs: 2'h2,
      mod_ofs: 8'h00, atten: 8'h22};
    prev = alias_id;
    i_shelf.send(msg);
    #1 `CHK("swap reject", 1'h1, cfg_reject)
    repeat (3) @(posedge clk_sys);
    #1 `CHK("alias kept", prev, alias_id)
    msg.module_type = TYPE_ID;
    i_shelf.send(msg);
    repeat (4) @(posedge clk_sys);
    boot(1'h1, 1'h0, 40);
    `CHK("swap alias", 8'h33, alias_id)
    `CHK("swap reboot", 6'h1B, seq)
    `CHK("swap level", 8'h22, atten)
    rd(ADDR_POWER);
    `CHK("video drop", {8'hF0, 8'h70}, rd_val)
    stop_test;
  end
endmodule  // tmc_ctrl_test

/* tb/tmc_shelf_model.sv */
// Shelf control module model that sends quick-swap messages
module tmc_shelf_model
  import tmc_pkg::*;
(
  input wire logic clk_sys,
  output tmc_cfg_t cfg,
  output logic cfg_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle lines at time zero
  initial begin
    cfg = '0;
    cfg_valid = 1'h0;
  end
  // Whole message for one cycle, then lines no longer hold it
  task automatic send(input tmc_cfg_t msg);
    @(posedge clk_sys);
    cfg <= msg;
    cfg_valid <= 1'h1;
    @(posedge clk_sys);
    cfg_valid <= 1'h0;
    cfg <= ~msg;
  endtask
endmodule  // tmc_shelf_model
